// *** rtl/ucb_pkg.sv ***
// constants shared by the serial channel control block
package ucb_pkg;
    // ==========================================
    // register word offsets (byte addresses)
    localparam logic [7:0] OFF_STATUS_A   = 8'h00;
    localparam logic [7:0] OFF_DATA       = 8'h04;
    localparam logic [7:0] OFF_CTRL_B     = 8'h08;
    localparam logic [7:0] OFF_CTRL_C     = 8'h0C;
    localparam logic [7:0] OFF_BAUD_LOW   = 8'h10;
    localparam logic [7:0] OFF_BAUD_HIGH  = 8'h14;
    localparam logic [7:0] OFF_GLOBAL_IE  = 8'h18;
    // ==========================================
    // ctrl_status_b fields
    localparam int B_RX_IE    = 7;
    localparam int B_TX_IE    = 6;
    localparam int B_EMPTY_IE = 5;
    localparam int B_RX_EN    = 4;
    localparam int B_TX_EN    = 3;
    localparam int B_SIZE_HI  = 2;
    localparam int B_RX_NINTH = 1;
    localparam int B_TX_NINTH = 0;
    // ==========================================
    // ctrl_status_c fields
    localparam int C_SYNC     = 6;
    localparam int C_PAR_HI   = 5;
    localparam int C_PAR_LO   = 4;
    localparam int C_STOP2    = 3;
    localparam int C_SIZE_HI  = 2;
    localparam int C_SIZE_LO  = 1;
    localparam int C_POL      = 0;
    // ==========================================
    // status word fields and global enable
    localparam int A_RX_DONE  = 7;
    localparam int A_TX_DONE  = 6;
    localparam int A_EMPTY    = 5;
    localparam int A_FRAME    = 4;
    localparam int A_OVERRUN  = 3;
    localparam int A_PARITY   = 2;
    localparam int G_IE       = 7;
    // ==========================================
    // reset values and timing counts
    localparam logic [7:0]  RST_CTRL_B   = 8'h00;
    localparam logic [7:0]  RST_CTRL_C   = 8'h06;
    localparam logic [11:0] RST_BAUD     = 12'h000;
    localparam logic [3:0]  OSMP_LAST    = 4'hF;
    localparam logic [3:0]  OSMP_HALF    = 4'h7;
    localparam logic [1:0]  RX_DEPTH     = 2'h2;
    localparam logic [3:0]  MAX_BITS     = 4'h9;
    localparam logic [2:0]  SIZE_9BIT    = 3'h7;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ucb_state_t;
endpackage

// *** rtl/ucb_usart.sv ***
// serial channel: control registers, baud prescaler, transmitter and receiver
`timescale 1ns/10ps
// Contract
// RQ1: rx done request needs its enable, global enable and rx done flag.
// RQ2: tx done request needs its enable, global enable and tx done flag.
// RQ3: empty request needs its enable, global enable and buffer empty flag.
// RQ4: receiver enable turns on receiver and takes the input pin.
// RQ5: disabling receiver flushes buffer, clearing frame, overrun and parity flags.
// RQ6: transmitter enable turns on transmitter and takes the output pin.
// RQ7: cleared transmitter enable waits until shifter and buffer empty, then releases.
// RQ8: received ninth bit readable in control b; software reads it first.
// RQ9: writable ninth bit sent as ninth data bit; software writes it first.
// RQ10: mode select 0 means asynchronous, 1 synchronous.
// RQ11: transmitter adds parity over data bits when parity enabled.
// RQ12: parity code 00 off, 01 reserved, 10 even, 11 odd; both directions.
// RQ13: receiver checks parity and flags a mismatch as parity error.
// RQ14: transmitter sends one or two stop bits; receiver ignores the setting.
// RQ15: size code from b high bit and c low bits; 5,6,7,8,9 bits.
// RQ16: sync polarity 0 launches on rising, samples on falling; 1 reverses.
// RQ17: divisor is 12 bits, high four in high register, low eight in low.
// RQ18: writing low baud register reloads the prescaler at once.
// RQ19: software keeps baud steady while frames are in flight.
// RQ20: software writes zeros to reserved baud and control c bits.
// RQ21: software writes polarity zero in asynchronous mode.
// RQ22: rx done flag high while receive buffer holds unread data.
// RQ23: buffer empty flag high when buffer can accept data; set by reset.
// RQ24: ninth bit stored with its frame and read from buffer head.
module ucb_usart
    import ucb_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_rxd,
    output logic             o_txd,
    output logic             o_txd_take,
    output logic             o_rxd_take,
    output logic             o_xck,
    output logic             o_xck_oe,
    output logic             o_irq_rx_done,
    output logic             o_irq_tx_done,
    output logic             o_irq_empty
);
    // ==========================================
    // registers
    logic [7:0]  ctrl_b_q;
    logic [7:0]  ctrl_c_q;
    logic [7:0]  baud_low_q;
    logic [3:0]  baud_high_q;
    logic        global_ie_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic [11:0] presc_q;
    logic        xck_q;
    logic        tx_own_q;
    logic [8:0]  tx_buf_q;
    logic        tx_full_q;
    logic        tx_done_q;
    ucb_state_t  tx_st_q;
    logic [8:0]  tx_sh_q;
    logic [3:0]  tx_idx_q;
    logic [3:0]  tx_sub_q;
    logic        tx_par_q;
    logic        tx_stop_q;
    logic        txd_q;
    ucb_state_t  rx_st_q;
    logic [8:0]  rx_sh_q;
    logic [3:0]  rx_idx_q;
    logic [3:0]  rx_sub_q;
    logic        rx_pe_q;
    logic [10:0] rx_mem_q [2];
    logic        rx_wp_q;
    logic        rx_rp_q;
    logic [1:0]  rx_cnt_q;
    logic        dor_q;

    // ==========================================
    // bus decode
    wire         req      = i_wb_cyc & i_wb_stb;
    wire         acc      = req & ack_q;
    wire         wr0      = acc & i_wb_we & i_wb_sel[0];
    wire         wr_a     = wr0 & (i_wb_adr == OFF_STATUS_A);
    wire         wr_data  = wr0 & (i_wb_adr == OFF_DATA);
    wire         wr_b     = wr0 & (i_wb_adr == OFF_CTRL_B);
    wire         wr_c     = wr0 & (i_wb_adr == OFF_CTRL_C);
    wire         wr_lo    = wr0 & (i_wb_adr == OFF_BAUD_LOW);
    wire         wr_hi    = wr0 & (i_wb_adr == OFF_BAUD_HIGH);
    wire         wr_g     = wr0 & (i_wb_adr == OFF_GLOBAL_IE);
    wire         rd_data  = acc & ~i_wb_we & (i_wb_adr == OFF_DATA);

    // ==========================================
    // configuration decode
    wire         rx_en    = ctrl_b_q[B_RX_EN];
    wire         tx_en    = ctrl_b_q[B_TX_EN];
    wire         sync_m   = ctrl_c_q[C_SYNC];                                 // RQ10
    wire         par_en   = ctrl_c_q[C_PAR_HI];                               // RQ12
    wire         par_odd  = ctrl_c_q[C_PAR_LO];                               // RQ12
    wire         two_stop = ctrl_c_q[C_STOP2];                                // RQ14
    wire [2:0]   size     = {ctrl_b_q[B_SIZE_HI], ctrl_c_q[C_SIZE_HI:C_SIZE_LO]}; // RQ15
    // reserved codes fall back to the 8-bit width
    wire [3:0]   nbits    = (size == SIZE_9BIT) ? MAX_BITS :
                            (size[2] ? 4'h8 : {2'b01, size[1:0]} + 4'h1);   // RQ15
    wire [8:0]   dmask    = 9'h1FF >> (MAX_BITS - nbits);
    wire [11:0]  divisor  = {baud_high_q, baud_low_q};                        // RQ17

    // ==========================================
    // baud prescaler and transfer clock
    wire         tick     = (presc_q == 12'h000);
    wire         launch   = tick & (xck_q == ctrl_c_q[C_POL]);                // RQ16
    wire         sample   = tick & (xck_q != ctrl_c_q[C_POL]);                // RQ16
    // a reload restarts the count so the new rate applies immediately
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            presc_q <= RST_BAUD;
            xck_q   <= 1'b0;
        end else begin
            if (wr_lo)
                presc_q <= {baud_high_q, i_wb_dat[7:0]};                       // RQ18
            else if (tick)
                presc_q <= divisor;
            else
                presc_q <= presc_q - 12'h001;
            if (!sync_m)
                xck_q <= 1'b0;
            else if (tick)
                xck_q <= ~xck_q;
        end
    end

    // ==========================================
    // register writes
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_b_q    <= RST_CTRL_B;
            ctrl_c_q    <= RST_CTRL_C;
            baud_low_q  <= RST_BAUD[7:0];
            baud_high_q <= RST_BAUD[11:8];
            global_ie_q <= 1'b0;
        end else begin
            if (wr_b)
                ctrl_b_q <= {i_wb_dat[7:2], 1'b0, i_wb_dat[0]};
            if (wr_c)
                ctrl_c_q <= i_wb_dat[7:0];
            if (wr_lo)
                baud_low_q <= i_wb_dat[7:0];
            if (wr_hi)
                baud_high_q <= i_wb_dat[3:0];                                 // RQ17
            if (wr_g)
                global_ie_q <= i_wb_dat[G_IE];
        end
    end

    // ==========================================
    // bus answer: one wait state, data latched with the ack
    wire [10:0]  rx_head  = rx_mem_q[rx_rp_q];
    wire         rx_done  = (rx_cnt_q != 2'h0);                               // RQ22
    wire         empty    = ~tx_full_q;                                       // RQ23
    wire [7:0]   stat_a   = {rx_done, tx_done_q, empty, rx_head[10] & rx_done,
                             dor_q, rx_head[9] & rx_done, 2'b00};             // RQ5
    wire [7:0]   ctrl_b_r = {ctrl_b_q[7:2], rx_head[8] & rx_done, ctrl_b_q[0]}; // RQ8 RQ24
    wire [7:0]   rd_mux   = (i_wb_adr == OFF_STATUS_A)  ? stat_a :
                            (i_wb_adr == OFF_DATA)      ? rx_head[7:0] & {8{rx_done}} :
                            (i_wb_adr == OFF_CTRL_B)    ? ctrl_b_r :
                            (i_wb_adr == OFF_CTRL_C)    ? ctrl_c_q :
                            (i_wb_adr == OFF_BAUD_LOW)  ? baud_low_q :
                            (i_wb_adr == OFF_BAUD_HIGH) ? {4'h0, baud_high_q} :
                            (i_wb_adr == OFF_GLOBAL_IE) ? {global_ie_q, 7'h00} : 8'h00;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= req & ~ack_q;
            rdat_q <= {24'h00_0000, rd_mux};
        end
    end
    assign o_wb_ack = ack_q;
    assign o_wb_dat = rdat_q;

    // ==========================================
    // interrupt requests
    assign o_irq_rx_done = ctrl_b_q[B_RX_IE] & global_ie_q & rx_done;        // RQ1
    assign o_irq_tx_done = ctrl_b_q[B_TX_IE] & global_ie_q & tx_done_q;      // RQ2
    assign o_irq_empty   = ctrl_b_q[B_EMPTY_IE] & global_ie_q & empty;       // RQ3

    // ==========================================
    // transmitter
    wire         tx_strb  = sync_m ? launch : (tick & (tx_sub_q == OSMP_LAST)); // RQ16
    wire         tx_load  = (tx_st_q == ST_IDLE) & tx_full_q & tx_own_q & (~sync_m | launch);
    wire         tx_end   = (tx_st_q == ST_STOP) & tx_strb & ~(two_stop & ~tx_stop_q);
    wire         tx_idle  = (tx_st_q == ST_IDLE) & ~tx_full_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tx_own_q  <= 1'b0;
            tx_buf_q  <= 9'h000;
            tx_full_q <= 1'b0;
            tx_done_q <= 1'b0;
        end else begin
            // pin stays ours until the last pending frame is out
            if (tx_en)
                tx_own_q <= 1'b1;                                             // RQ6
            else if (tx_idle)
                tx_own_q <= 1'b0;                                             // RQ7
            if (wr_data & ~tx_full_q) begin
                tx_buf_q  <= {ctrl_b_q[B_TX_NINTH], i_wb_dat[7:0]};           // RQ9
                tx_full_q <= 1'b1;
            end else if (tx_load) begin
                tx_full_q <= 1'b0;
            end
            // a completing frame wins over a software clear
            if (tx_end & ~tx_full_q)
                tx_done_q <= 1'b1;
            else if (wr_a & i_wb_dat[A_TX_DONE])
                tx_done_q <= 1'b0;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            tx_st_q   <= ST_IDLE;
            tx_sh_q   <= 9'h000;
            tx_idx_q  <= 4'h0;
            tx_sub_q  <= 4'h0;
            tx_par_q  <= 1'b0;
            tx_stop_q <= 1'b0;
            txd_q     <= 1'b1;
        end else begin
            if (tick)
                tx_sub_q <= tx_sub_q + 4'h1;
            unique case (tx_st_q)
                ST_IDLE: begin
                    if (tx_load) begin
                        tx_sh_q  <= tx_buf_q & dmask;
                        tx_par_q <= (^(tx_buf_q & dmask)) ^ par_odd;          // RQ11
                        tx_sub_q <= 4'h0;
                        txd_q    <= 1'b0;
                        tx_st_q  <= ST_START;
                    end
                end
                ST_START: begin
                    if (tx_strb) begin
                        txd_q    <= tx_sh_q[0];
                        tx_sh_q  <= tx_sh_q >> 1;
                        tx_idx_q <= 4'h1;
                        tx_st_q  <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tx_strb) begin
                        if (tx_idx_q == nbits) begin
                            txd_q     <= par_en ? tx_par_q : 1'b1;            // RQ11
                            tx_stop_q <= 1'b0;
                            tx_st_q   <= par_en ? ST_PAR : ST_STOP;
                        end else begin
                            txd_q    <= tx_sh_q[0];
                            tx_sh_q  <= tx_sh_q >> 1;
                            tx_idx_q <= tx_idx_q + 4'h1;
                        end
                    end
                end
                ST_PAR: begin
                    if (tx_strb) begin
                        txd_q   <= 1'b1;
                        tx_st_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (tx_strb) begin
                        tx_stop_q <= 1'b1;                                    // RQ14
                        if (tx_end)
                            tx_st_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    assign o_txd      = txd_q;
    assign o_txd_take = tx_own_q;                                             // RQ6
    assign o_rxd_take = rx_en;                                                // RQ4
    assign o_xck      = xck_q;
    assign o_xck_oe   = sync_m & (tx_own_q | rx_en);

    // ==========================================
    // receiver and two-entry buffer
    wire         rx_strb  = sync_m ? sample : (tick & (rx_sub_q == OSMP_LAST));
    wire         rx_push  = rx_en & (rx_st_q == ST_STOP) & rx_strb;
    wire         rx_pop   = rd_data & rx_done;
    wire         rx_full  = (rx_cnt_q == RX_DEPTH);
    wire         rx_store = rx_push & (~rx_full | rx_pop);
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_st_q  <= ST_IDLE;
            rx_sh_q  <= 9'h000;
            rx_idx_q <= 4'h0;
            rx_sub_q <= 4'h0;
            rx_pe_q  <= 1'b0;
        end else if (!rx_en) begin
            rx_st_q  <= ST_IDLE;
        end else begin
            if (tick)
                rx_sub_q <= rx_sub_q + 4'h1;
            unique case (rx_st_q)
                ST_IDLE: begin
                    rx_sh_q  <= 9'h000;
                    rx_idx_q <= 4'h0;
                    rx_pe_q  <= 1'b0;
                    if (sync_m ? (sample & ~i_rxd) : (tick & ~i_rxd)) begin   // RQ16
                        rx_sub_q <= 4'h0;
                        rx_st_q  <= sync_m ? ST_DATA : ST_START;
                    end
                end
                ST_START: begin
                    // recheck mid start bit to reject glitches
                    if (tick & (rx_sub_q == OSMP_HALF)) begin
                        rx_sub_q <= 4'h0;
                        rx_st_q  <= i_rxd ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rx_strb) begin
                        rx_sh_q[rx_idx_q] <= i_rxd;
                        rx_idx_q          <= rx_idx_q + 4'h1;
                        if (rx_idx_q + 4'h1 == nbits)
                            rx_st_q <= par_en ? ST_PAR : ST_STOP;
                    end
                end
                ST_PAR: begin
                    if (rx_strb) begin
                        rx_pe_q <= i_rxd != ((^rx_sh_q) ^ par_odd);           // RQ13
                        rx_st_q <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    // only the first stop bit is checked
                    if (rx_strb)
                        rx_st_q <= ST_IDLE;                                   // RQ14
                end
            endcase
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_mem_q[0] <= 11'h000;
            rx_mem_q[1] <= 11'h000;
            rx_wp_q     <= 1'b0;
            rx_rp_q     <= 1'b0;
            rx_cnt_q    <= 2'h0;
            dor_q       <= 1'b0;
        end else if (!rx_en) begin
            rx_wp_q  <= 1'b0;                                                 // RQ5
            rx_rp_q  <= 1'b0;
            rx_cnt_q <= 2'h0;
            dor_q    <= 1'b0;
        end else begin
            if (rx_store) begin
                rx_mem_q[rx_wp_q] <= {~i_rxd, rx_pe_q, rx_sh_q};              // RQ24
                rx_wp_q           <= ~rx_wp_q;
            end
            if (rx_pop)
                rx_rp_q <= ~rx_rp_q;
            rx_cnt_q <= rx_cnt_q + {1'b0, rx_store} - {1'b0, rx_pop};         // RQ22
            if (rx_push & ~rx_store)
                dor_q <= 1'b1;
            else if (rx_pop)
                dor_q <= 1'b0;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_low_write;
        wr_lo ##1 1'b1;
    endsequence
    sequence s_tx_drain;
        o_txd_take && !tx_en && !tx_idle;
    endsequence
    chk_rx_irq_gate: assert property (o_irq_rx_done |-> rx_cnt_q != 2'h0 && global_ie_q) // RQ1
        else $error("rx done request without data or enable");
    chk_tx_irq_gate: assert property (o_irq_tx_done |-> tx_done_q && ctrl_b_q[B_TX_IE]) // RQ2
        else $error("tx done request without flag or enable");
    chk_empty_irq_gate: assert property (o_irq_empty |-> !tx_full_q && global_ie_q) // RQ3
        else $error("empty request while buffer full");
    chk_rx_pin_take: assert property ($rose(ctrl_b_q[B_RX_EN]) |-> o_rxd_take) // RQ4
        else $error("receiver enabled without pin");
    chk_rx_flush: assert property ($fell(rx_en) |=> rx_cnt_q == 2'h0 && !dor_q && !o_irq_rx_done) // RQ5
        else $error("receive buffer not flushed");
    chk_tx_hold_pin: assert property (s_tx_drain |=> o_txd_take) // RQ7
        else $error("pin released before transmitter drained");
    chk_tx_pin_take: assert property ($rose(tx_en) |=> o_txd_take) // RQ6
        else $error("transmitter enabled without pin");
    chk_baud_reload: assert property (s_low_write |-> presc_q == divisor) // RQ18
        else $error("prescaler not reloaded");
    chk_empty_reset: assert property ($rose(i_rst_n) |-> !tx_full_q) // RQ23
        else $error("buffer not empty after reset");
    chk_sync_launch: assert property (sync_m && tx_st_q == ST_DATA && $changed(txd_q) |-> $past(launch)) // RQ16
        else $error("sync data changed off the launch edge");
endmodule

// *** tb/tb.sv ***
// self-checking bench for the serial channel control block
`timescale 1ns/10ps
module tb
    import ucb_pkg::*;
;
    logic        clk, rst_n, req, we, ack, txd, rxd, tx_take, rx_take, xck, xck_oe, irq_rx, irq_tx, irq_em;
    logic [7:0]  adr, r, cb;
    logic [31:0] wdat, rdat, seed;
    logic [15:0] got, f;
    logic [8:0]  d;
    logic [7:0]  exp_q [$];
    int          fails, comparisons, nb, pm, s2, ln, n;
    ucb_usart dut (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_rxd(rxd), .o_txd(txd),
        .o_txd_take(tx_take), .o_rxd_take(rx_take), .o_xck(xck), .o_xck_oe(xck_oe), .o_irq_rx_done(irq_rx),
        .o_irq_tx_done(irq_tx), .o_irq_empty(irq_em));
    ucb_peer peer (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ====
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // reference frame, lsb first, stop level beyond the end
    function automatic logic [15:0] frm(input logic [8:0] v, input int k, input int m);
        logic [15:0] q;
        logic        p;
        q = '1;
        q[0] = 1'b0;
        p = 1'b0;
        for (int i = 0; i < k; i++) begin
            q[i + 1] = v[i];
            p = p ^ v[i];
        end
        if (m >= 2) q[k + 1] = p ^ (m == 3);
        return q;
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // classic single cycle; no fixed latency assumed
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
        int k;
        @(posedge clk);
        req <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h00_0000, v};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) fails++;
        r = rdat[7:0];
        req <= 1'b0;
    endtask
    task automatic conclude();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        conclude();
    end
    // ====
    // main sequence
    initial begin
        {req, we, rst_n, adr, wdat, fails, comparisons} = '0;
        seed = 32'h71be_2d0f;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wb(0, OFF_CTRL_B, 8'h00);
        chk(r, 8'h00);
        wb(0, OFF_CTRL_C, 8'h00);
        chk(r, 8'h06);
        wb(0, OFF_STATUS_A, 8'h00);
        chk(r & 8'h20, 8'h20);
        wb(0, 8'h3C, 8'h00);
        chk(r, 8'h00);
        wb(1, OFF_BAUD_HIGH, 8'h0A);
        wb(1, OFF_BAUD_LOW, 8'h5C);
        wb(0, OFF_BAUD_HIGH, 8'h00);
        chk(r, 8'h0A);
        wb(0, OFF_BAUD_LOW, 8'h00);
        chk(r, 8'h5C);
        wb(1, OFF_BAUD_HIGH, 8'h00);
        wb(1, OFF_BAUD_LOW, 8'h00);
        wb(1, OFF_GLOBAL_IE, 8'h80);
        wb(1, OFF_CTRL_B, 8'h20);
        @(posedge clk);
        chk(irq_em, 1'b1);
        wb(1, OFF_GLOBAL_IE, 8'h00);
        @(posedge clk);
        chk(irq_em, 1'b0);
        wb(1, OFF_GLOBAL_IE, 8'h80);
        // every size, parity code and stop count; last pass is nine bits
        for (int i = 0; i < 5; i++) begin
            nb = (i == 4) ? 9 : 5 + i;
            pm = i % 4;
            s2 = i % 2;
            ln = 2 + nb + s2 + ((pm >= 2) ? 1 : 0);
            cb = (i == 4) ? 8'h4D : 8'h48;
            seed = xs(seed);
            d = {i == 4, seed[7:0]};
            wb(1, OFF_CTRL_C, {2'b00, pm[1:0], s2[0], (i == 4) ? 2'b11 : i[1:0], 1'b0});
            wb(1, OFF_CTRL_B, cb);
            repeat (2) @(posedge clk);
            chk(tx_take, 1'b1);
            fork
                peer.catch_frame(16, ln, got);
                begin
                    wb(1, OFF_DATA, d[7:0]);
                    wb(1, OFF_CTRL_B, cb & 8'hF7);
                    chk(tx_take, 1'b1);
                end
            join
            chk(got, frm(d, nb, pm));
            n = 0;
            do begin
                wb(0, OFF_STATUS_A, 8'h00);
                n++;
            end while (r[A_TX_DONE] !== 1'b1 && n < 100);
            repeat (2) @(posedge clk);
            chk(tx_take, 1'b0);
            chk(irq_tx, 1'b1);
            wb(1, OFF_STATUS_A, 8'h40);
            @(posedge clk);
            chk(irq_tx, 1'b0);
        end
        // two frames fill the receive buffer, second with bad parity
        wb(1, OFF_CTRL_C, 8'h26);
        wb(1, OFF_CTRL_B, 8'h90);
        repeat (2) @(posedge clk);
        chk(rx_take, 1'b1);
        seed = xs(seed);
        exp_q.push_back(seed[7:0]);
        exp_q.push_back(seed[15:8]);
        peer.send(16, frm({1'b0, seed[7:0]}, 8, 2), 11);
        f = frm({1'b0, seed[15:8]}, 8, 2);
        f[9] = ~f[9];
        peer.send(16, f, 11);
        repeat (16) @(posedge clk);
        wb(0, OFF_STATUS_A, 8'h00);
        chk(r & 8'h84, 8'h80);
        chk(irq_rx, 1'b1);
        wb(0, OFF_DATA, 8'h00);
        chk(r, exp_q.pop_front());
        wb(0, OFF_STATUS_A, 8'h00);
        chk(r & 8'h84, 8'h84);
        wb(0, OFF_DATA, 8'h00);
        chk(r, exp_q.pop_front());
        wb(0, OFF_STATUS_A, 8'h00);
        chk(r & 8'h80, 8'h00);
        chk(irq_rx, 1'b0);
        // nine bit frame, then receiver off flushes it
        wb(1, OFF_CTRL_B, 8'h14);
        f = frm(9'h1A5, 9, 2);
        f[10] = ~f[10];
        peer.send(16, f, 12);
        repeat (16) @(posedge clk);
        wb(0, OFF_CTRL_B, 8'h00);
        chk(r[B_RX_NINTH], 1'b1);
        wb(0, OFF_STATUS_A, 8'h00);
        chk(r & 8'h84, 8'h84);
        wb(1, OFF_CTRL_B, 8'h04);
        repeat (2) @(posedge clk);
        wb(0, OFF_STATUS_A, 8'h00);
        chk(r & 8'h9C, 8'h00);
        chk(rx_take, 1'b0);
        wb(1, OFF_CTRL_C, 8'h46);
        wb(1, OFF_CTRL_B, 8'h08);
        // one synchronous frame per clock polarity, two cycles per bit
        for (int p = 0; p < 2; p++) begin
            wb(1, OFF_CTRL_C, 8'h46 | p[7:0]);
            repeat (2) @(posedge clk);
            chk(xck_oe, 1'b1);
            seed = xs(seed);
            fork
                peer.catch_frame(2, 10, got);
                wb(1, OFF_DATA, seed[7:0]);
            join
            chk(got, frm({1'b0, seed[7:0]}, 8, 0));
        end
        wb(1, OFF_CTRL_C, 8'h06);
        repeat (2) @(posedge clk);
        chk({xck_oe, xck}, 2'b00);
        conclude();
    end
endmodule

// *** tb/ucb_peer.sv ***
// serial peer model on the far side of the line pins
`timescale 1ns/10ps
module ucb_peer (
    input  wire logic i_clk,
    input  wire logic i_txd,
    output logic      o_rxd
);
    // idle line rests high, as a released asynchronous line does
    initial o_rxd = 1'b1;
    // ====
    // send bits lsb first, bc clocks per bit
    task automatic send(input int bc, input logic [15:0] f, input int len);
        for (int i = 0; i < len; i++) begin
            @(posedge i_clk);
            o_rxd <= f[i];
            repeat (bc - 1) @(posedge i_clk);
        end
        @(posedge i_clk);
        o_rxd <= 1'b1;
    endtask
    // sample mid bit; unsampled positions read as stop level
    task automatic catch_frame(input int bc, input int len, output logic [15:0] f);
        f = '1;
        @(negedge i_txd);
        repeat (bc / 2) @(posedge i_clk);
        for (int i = 0; i < len; i++) begin
            f[i] = i_txd;
            repeat (bc) @(posedge i_clk);
        end
    endtask
endmodule
